// file: hw/dcc_pkg.sv
// Package with register map, field layouts and types of the converter controller.
package dcc_pkg;
  localparam int DATA_W = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_PRIMARY_CONTROL_REG = 6'h00;
  localparam logic [5:0] IDX_SECONDARY_CONTROL_REG = 6'h01;
  localparam logic [5:0] IDX_EVENT_CONTROL_REG = 6'h02;
  localparam logic [5:0] IDX_INTENCLR = 6'h04;
  localparam logic [5:0] IDX_INTENSET = 6'h05;
  localparam logic [5:0] IDX_INTERRUPT_FLAG_REG = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_DATA = 6'h08;
  localparam logic [5:0] IDX_DATA_BUFFER_REG = 6'h0C;
  localparam logic [5:0] IDX_DBGCTRL = 6'h0F;
  // Primary control bit positions.
  localparam int CA_SOFT_RESET_BIT = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_RUNSTDBY = 2;
  // Event control bit positions.
  localparam int EV_START_EVENT_INPUT_ENABLE = 0;
  localparam int EV_EMPTY_EVENT_OUTPUT_ENABLE = 1;
  localparam int EV_INVEI = 2;
  // Interrupt flag and status bit positions.
  localparam int FL_UNDERRUN = 0;
  localparam int FL_EMPTY = 1;
  localparam int FL_SYNCRDY = 2;
  localparam int STATUS_BUSY = 7;
  // Reset values and synchroniser depth.
  localparam logic [7:0] SECONDARY_CONTROL_REG_RST = 8'h00;
  localparam logic [2:0] EVENT_CONTROL_REG_RST = 3'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam int SYNC_STAGES = 2;
  // Reference choices.
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  typedef struct packed {
    logic [1:0] reference_select_field;
    logic [1:0] rsv;
    logic vpd;
    logic leftadj;
    logic ioen;
    logic external_output_enable;
  } dcc_secondary_control_reg_t;

  typedef struct packed {
    logic event_edge_invert_bit;
    logic empty_event_output_enable;
    logic start_event_input_enable;
  } dcc_event_control_reg_t;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_PRIMARY_CONTROL_REG,
    ACT_DATA,
    ACT_BUF
  } dcc_act_t;
endpackage : dcc_pkg

// file: hw/dcc_sync.sv
// Toggle handshake that carries a write request through a flip-flop chain.
`timescale 1ns/1ps
module dcc_sync #(
  parameter int STAGES = dcc_pkg::SYNC_STAGES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req,
  output logic busy,
  output logic done
);
  logic tgl_r;
  logic [STAGES-1:0] chain_r;
  logic last_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tgl_r <= 1'b0;
      chain_r <= '0;
      last_r <= 1'b0;
    end
    else
    begin
      if (req)
      begin
        tgl_r <= ~tgl_r;
      end
      chain_r <= {chain_r[STAGES-2:0], tgl_r};
      last_r <= chain_r[STAGES-1];
    end
  end

  // The first stage is only read by the next stage.
  assign done = chain_r[STAGES-1] ^ last_r;
  assign busy = tgl_r ^ last_r;
endmodule : dcc_sync

// file: hw/dcc_top.sv
// Converter controller with register file, data buffer, events and write synchronisation.
`timescale 1ns/1ps
module dcc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_protect,
  input wire logic debugger_access,
  input wire logic debug_halt,
  input wire logic standby,
  input wire logic start_event,
  output logic [dcc_pkg::DATA_W-1:0] dac_code,
  output logic conv_start,
  output logic [1:0] reference_select_field,
  output logic analog_output_pin_en,
  output logic internal_output_en,
  output logic empty_event,
  output logic irq
);
  logic enable_r;
  logic runstdby_r;
  logic run_dbg_r;
  dcc_pkg::dcc_secondary_control_reg_t secondary_control_reg_r;
  dcc_pkg::dcc_event_control_reg_t event_control_reg_r;
  logic [2:0] inten_r;
  logic [2:0] flag_r;
  logic [15:0] data_r;
  logic [15:0] buf_r;
  logic buf_full_r;
  logic [31:0] prdata_r;
  logic [dcc_pkg::DATA_W-1:0] code_r;
  logic conv_r;
  logic empty_evt_r;
  logic evt_d_r;
  dcc_pkg::dcc_act_t act_r;
  logic [15:0] pend_r;
  logic pend_soft_reset_bit_r;
  logic pend_en_r;

  logic wr;
  logic rd_setup;
  logic [5:0] idx;
  logic mapped;
  logic sync_reg;
  logic protected_reg;
  logic prot_err;
  logic busy;
  logic done;
  logic sync_err;
  logic wr_ok;
  logic sync_req;
  logic soft_clr;
  logic halted;
  logic evt_edge;
  logic start_ok;
  logic data_done;
  logic buf_done;
  logic [15:0] data_nxt;

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i <= dcc_pkg::IDX_DATA && i != 6'h03) || i == dcc_pkg::IDX_DATA_BUFFER_REG
      || i == dcc_pkg::IDX_DBGCTRL;
  endfunction : is_mapped

  function automatic logic [dcc_pkg::DATA_W-1:0] to_code(input logic [15:0] d,
      input logic left);
    to_code = left ? d[15:6] : d[dcc_pkg::DATA_W-1:0];
  endfunction : to_code

  assign idx = paddr[7:2];
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = is_mapped(idx);
  assign sync_reg = idx == dcc_pkg::IDX_PRIMARY_CONTROL_REG || idx == dcc_pkg::IDX_DATA
    || idx == dcc_pkg::IDX_DATA_BUFFER_REG;
  assign protected_reg = idx != dcc_pkg::IDX_INTERRUPT_FLAG_REG && idx != dcc_pkg::IDX_DATA_BUFFER_REG;
  assign prot_err = write_protect && protected_reg && !debugger_access;
  assign sync_err = sync_reg && busy;
  assign wr_ok = wr && mapped && !prot_err && !sync_err;
  assign sync_req = wr_ok && sync_reg;

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && (prot_err || sync_err)));
  assign prdata = prdata_r;

  dcc_sync #(
    .STAGES(dcc_pkg::SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .req(sync_req),
    .busy(busy),
    .done(done)
  );

  // Pending synchronised write; a second one is refused while this one is in flight.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      act_r <= dcc_pkg::ACT_NONE;
      pend_r <= 16'h0000;
      pend_soft_reset_bit_r <= 1'b0;
      pend_en_r <= 1'b0;
    end
    else if (sync_req)
    begin
      pend_r <= pwdata[15:0];
      pend_soft_reset_bit_r <= pwdata[dcc_pkg::CA_SOFT_RESET_BIT];
      pend_en_r <= pwdata[dcc_pkg::CA_ENABLE];
      if (idx == dcc_pkg::IDX_PRIMARY_CONTROL_REG)
      begin
        act_r <= dcc_pkg::ACT_PRIMARY_CONTROL_REG;
      end
      else if (idx == dcc_pkg::IDX_DATA)
      begin
        act_r <= dcc_pkg::ACT_DATA;
      end
      else
      begin
        act_r <= dcc_pkg::ACT_BUF;
      end
    end
    else if (done)
    begin
      act_r <= dcc_pkg::ACT_NONE;
    end
  end

  assign soft_clr = done && act_r == dcc_pkg::ACT_PRIMARY_CONTROL_REG && pend_soft_reset_bit_r;
  assign data_done = done && act_r == dcc_pkg::ACT_DATA;
  assign buf_done = done && act_r == dcc_pkg::ACT_BUF;
  assign halted = debug_halt && !run_dbg_r;
  assign evt_edge = event_control_reg_r.event_edge_invert_bit ? (evt_d_r && !start_event)
    : (!evt_d_r && start_event);
  assign start_ok = evt_edge && event_control_reg_r.start_event_input_enable && enable_r && !halted;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      evt_d_r <= 1'b0;
    end
    else
    begin
      evt_d_r <= start_event;
    end
  end

  // Primary control: enable and run-in-standby; the soft reset bit never stays set.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      enable_r <= 1'b0;
      runstdby_r <= 1'b0;
    end
    else if (soft_clr)
    begin
      enable_r <= 1'b0;
      runstdby_r <= 1'b0;
    end
    else if (done && act_r == dcc_pkg::ACT_PRIMARY_CONTROL_REG)
    begin
      enable_r <= pend_en_r;
      runstdby_r <= pend_r[dcc_pkg::CA_RUNSTDBY];
    end
  end

  // Configuration writes are ignored while the controller is on.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      secondary_control_reg_r <= dcc_pkg::SECONDARY_CONTROL_REG_RST;
      event_control_reg_r <= dcc_pkg::EVENT_CONTROL_REG_RST;
      run_dbg_r <= 1'b0;
    end
    else if (soft_clr)
    begin
      secondary_control_reg_r <= dcc_pkg::SECONDARY_CONTROL_REG_RST;
      event_control_reg_r <= dcc_pkg::EVENT_CONTROL_REG_RST;
      run_dbg_r <= 1'b0;
    end
    else if (wr_ok && !enable_r)
    begin
      if (idx == dcc_pkg::IDX_SECONDARY_CONTROL_REG)
      begin
        secondary_control_reg_r <= dcc_pkg::dcc_secondary_control_reg_t'({pwdata[7:6], 2'h0, pwdata[3:0]});
      end
      if (idx == dcc_pkg::IDX_EVENT_CONTROL_REG)
      begin
        event_control_reg_r <= dcc_pkg::dcc_event_control_reg_t'(pwdata[2:0]);
      end
      if (idx == dcc_pkg::IDX_DBGCTRL)
      begin
        run_dbg_r <= pwdata[0];
      end
    end
  end

  // Two-stage queue: a start event drains the buffer into the conversion register.
  always_comb
  begin
    data_nxt = data_r;
    if (start_ok && buf_full_r)
    begin
      data_nxt = buf_r;
    end
    if (data_done)
    begin
      data_nxt = pend_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_r <= dcc_pkg::DATA_RST;
      buf_r <= dcc_pkg::DATA_RST;
      buf_full_r <= 1'b0;
      conv_r <= 1'b0;
      empty_evt_r <= 1'b0;
    end
    else if (soft_clr)
    begin
      data_r <= dcc_pkg::DATA_RST;
      buf_r <= dcc_pkg::DATA_RST;
      buf_full_r <= 1'b0;
      conv_r <= 1'b0;
      empty_evt_r <= 1'b0;
    end
    else
    begin
      data_r <= data_nxt;
      conv_r <= data_done || (start_ok && buf_full_r);
      empty_evt_r <= start_ok && buf_full_r && !buf_done
        && event_control_reg_r.empty_event_output_enable;
      if (buf_done)
      begin
        buf_r <= pend_r;
        buf_full_r <= 1'b1;
      end
      else if (start_ok && buf_full_r)
      begin
        buf_full_r <= 1'b0;
      end
    end
  end

  // The code is registered each cycle from the next data value and leftadj, so it also moves on a soft reset or a leftadj write.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      code_r <= '0;
    end
    else
    begin
      code_r <= to_code(data_nxt, secondary_control_reg_r.leftadj);
    end
  end

  // Interrupt enables and sticky flags; a set in the clearing cycle wins.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      inten_r <= 3'h0;
      flag_r <= 3'h0;
    end
    else if (soft_clr)
    begin
      inten_r <= 3'h0;
      flag_r <= 3'h0;
    end
    else
    begin
      if (wr_ok && idx == dcc_pkg::IDX_INTENSET)
      begin
        inten_r <= inten_r | pwdata[2:0];
      end
      else if (wr_ok && idx == dcc_pkg::IDX_INTENCLR)
      begin
        inten_r <= inten_r & ~pwdata[2:0];
      end
      flag_r[dcc_pkg::FL_UNDERRUN] <= (start_ok && !buf_full_r)
        || (flag_r[dcc_pkg::FL_UNDERRUN]
        && !(wr_ok && idx == dcc_pkg::IDX_INTERRUPT_FLAG_REG && pwdata[dcc_pkg::FL_UNDERRUN]));
      flag_r[dcc_pkg::FL_EMPTY] <= (enable_r && !buf_full_r)
        || (flag_r[dcc_pkg::FL_EMPTY]
        && !(wr_ok && idx == dcc_pkg::IDX_INTERRUPT_FLAG_REG && pwdata[dcc_pkg::FL_EMPTY]));
      flag_r[dcc_pkg::FL_SYNCRDY] <= done
        || (flag_r[dcc_pkg::FL_SYNCRDY]
        && !(wr_ok && idx == dcc_pkg::IDX_INTERRUPT_FLAG_REG && pwdata[dcc_pkg::FL_SYNCRDY]));
    end
  end

  // Read data is captured in the setup cycle so it stands through the access cycle.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      case (idx)
        dcc_pkg::IDX_PRIMARY_CONTROL_REG: prdata_r <= {29'h0, runstdby_r, enable_r, 1'b0};
        dcc_pkg::IDX_SECONDARY_CONTROL_REG: prdata_r <= {24'h0, secondary_control_reg_r};
        dcc_pkg::IDX_EVENT_CONTROL_REG: prdata_r <= {29'h0, event_control_reg_r};
        dcc_pkg::IDX_INTENCLR: prdata_r <= {29'h0, inten_r};
        dcc_pkg::IDX_INTENSET: prdata_r <= {29'h0, inten_r};
        dcc_pkg::IDX_INTERRUPT_FLAG_REG: prdata_r <= {29'h0, flag_r};
        dcc_pkg::IDX_STATUS: prdata_r <= {24'h0, busy, 7'h0};
        dcc_pkg::IDX_DATA: prdata_r <= {16'h0, data_r};
        dcc_pkg::IDX_DATA_BUFFER_REG: prdata_r <= {16'h0, buf_r};
        dcc_pkg::IDX_DBGCTRL: prdata_r <= {31'h0, run_dbg_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign dac_code = code_r;
  assign conv_start = conv_r;
  assign empty_event = empty_evt_r;
  assign reference_select_field = secondary_control_reg_r.reference_select_field;
  // The driver is dropped in standby unless run-in-standby keeps it alive.
  assign analog_output_pin_en = enable_r && secondary_control_reg_r.external_output_enable
    && !(standby && !runstdby_r);
  assign internal_output_en = enable_r && secondary_control_reg_r.ioen;
  // Not gated by sleep, so a pending flag can wake the system.
  assign irq = |(flag_r & inten_r);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  irq_follows_flag_a: assert property (((flag_r & inten_r) != 3'h0) |-> irq)
    else $error("interrupt missing while flag and enable set");
  cfg_locked_a: assert property (enable_r && !soft_clr |=> $stable(secondary_control_reg_r))
    else $error("secondary control changed while enabled");
  sync_busy_a: assert property (sync_req |=> busy)
    else $error("busy not raised after synchronised write");
  sync_ends_a: assert property ($rose(busy) |-> ##[2:4] done)
    else $error("synchronisation did not complete in time");
  discard_busy_a: assert property (wr && mapped && sync_reg && busy |-> pslverr
      && !sync_req)
    else $error("write during busy was not refused");
  pin_gate_a: assert property (analog_output_pin_en |-> secondary_control_reg_r.external_output_enable
      && enable_r)
    else $error("output pin driven without enable");
  underrun_set_a: assert property (start_ok && !buf_full_r && !soft_clr
      |=> flag_r[dcc_pkg::FL_UNDERRUN])
    else $error("underrun flag not set");
  queue_move_a: assert property (start_ok && buf_full_r && !data_done && !soft_clr
      |=> data_r == $past(buf_r) && conv_start ##1 !conv_start || data_done)
    else $error("buffer not moved into conversion register");
  soft_reset_bit_clear_a: assert property (soft_clr |=> !enable_r && secondary_control_reg_r == dcc_pkg::SECONDARY_CONTROL_REG_RST
      && flag_r == 3'h0)
    else $error("soft reset left state behind");
  empty_set_a: assert property (enable_r && !buf_full_r && !soft_clr
      |=> flag_r[dcc_pkg::FL_EMPTY])
    else $error("empty flag not set");
  halt_block_a: assert property (debug_halt && !run_dbg_r |-> !start_ok)
    else $error("start accepted during debug halt");

  start_cov_c: cover property (start_ok && buf_full_r);
  underrun_cov_c: cover property (start_ok && !buf_full_r);
  discard_cov_c: cover property (sync_err && wr);
  soft_reset_bit_cov_c: cover property (soft_clr);
endmodule : dcc_top

// file: test/dcc_event_src.sv
// Event source model that raises start edges of the chosen polarity.
`timescale 1ns/1ps
module dcc_event_src (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic invert,
  output logic start_event
);
  // The idle level follows the polarity, so only the leading edge of a pulse is active.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      start_event <= 1'b0;
    else
      start_event <= fire ^ invert;
  end
endmodule : dcc_event_src

// file: test/dcc_top_tb_top.sv
// Self-checking testbench of the converter controller.
`timescale 1ns/1ps
module dcc_top_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic write_protect = 1'b0;
  logic debugger_access = 1'b0;
  logic debug_halt = 1'b0;
  logic standby = 1'b0;
  logic start_event;
  logic [9:0] dac_code;
  logic conv_start;
  logic [1:0] ref_sel;
  logic pin_en;
  logic int_en;
  logic empty_event;
  logic irq;
  logic ev_fire = 1'b0;
  logic ev_inv = 1'b0;
  logic [31:0] seed = 32'd38446;
  logic [31:0] rd;
  logic err;
  logic [9:0] v;
  logic [9:0] w;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_conv = 0;
  int n_empty = 0;
  int c0;

  always #20 core_clk = ~core_clk;

  dcc_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_protect(write_protect), .debugger_access(debugger_access),
    .debug_halt(debug_halt), .standby(standby), .start_event(start_event),
    .dac_code(dac_code), .conv_start(conv_start), .reference_select_field(ref_sel),
    .analog_output_pin_en(pin_en), .internal_output_en(int_en),
    .empty_event(empty_event), .irq(irq));

  dcc_event_src i_src (.core_clk(core_clk), .rst(rst), .fire(ev_fire), .invert(ev_inv),
    .start_event(start_event));

  always @(posedge core_clk)
  begin
    cycles++;
    if (conv_start === 1'b1)
      n_conv++;
    if (empty_event === 1'b1)
      n_empty++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  // Called just after a rising edge; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int g;
    g = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      g++;
    end while (pready !== 1'b1 && g < 50);
    rd = prdata;
    err = pslverr;
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic e);
    apb(1'b1, idx, d);
    idle();
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask : wr

  task automatic rdc(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    idle();
    chk(name, exp, rd);
  endtask : rdc

  // Synchronised writes are only safe once the busy flag has dropped.
  // Waiting here also spaces data loads by more than a conversion time.
  task automatic wait_sync();
    int i;
    for (i = 0; i < 20; i++)
    begin
      apb(1'b0, dcc_pkg::IDX_STATUS, 32'h0);
      idle();
      if (rd[dcc_pkg::STATUS_BUSY] === 1'b0)
        break;
    end
    chk("sync_busy_flag", 32'h0, {31'h0, rd[dcc_pkg::STATUS_BUSY]});
    repeat (2) @(posedge core_clk);
  endtask : wait_sync

  task automatic fire();
    ev_fire <= 1'b1;
    @(posedge core_clk);
    ev_fire <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : fire

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc("secondary_control_reg_rst", dcc_pkg::IDX_SECONDARY_CONTROL_REG, {24'h0, dcc_pkg::SECONDARY_CONTROL_REG_RST});
    rdc("event_control_reg_rst", dcc_pkg::IDX_EVENT_CONTROL_REG, {29'h0, dcc_pkg::EVENT_CONTROL_REG_RST});
    rdc("data_rst", dcc_pkg::IDX_DATA, {16'h0, dcc_pkg::DATA_RST});
    chk("ref_rst", {30'h0, dcc_pkg::REF_INTERNAL}, {30'h0, ref_sel});
    wr(6'h03, 32'h0, 1'b1);
    wr(dcc_pkg::IDX_SECONDARY_CONTROL_REG, 32'h83, 1'b0);
    chk("ref_ext", {30'h0, dcc_pkg::REF_EXTERNAL}, {30'h0, ref_sel});
    wr(dcc_pkg::IDX_EVENT_CONTROL_REG, 32'h3, 1'b0);
    wr(dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h2, 1'b0);
    wait_sync();
    chk("pin_en", 32'h1, {31'h0, pin_en});
    chk("int_en", 32'h1, {31'h0, int_en});
    wr(dcc_pkg::IDX_SECONDARY_CONTROL_REG, 32'h0, 1'b0);
    rdc("secondary_control_reg_locked", dcc_pkg::IDX_SECONDARY_CONTROL_REG, 32'h83);
    standby <= 1'b1;
    @(posedge core_clk);
    chk("pin_sleep", 32'h0, {31'h0, pin_en});
    wr(dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h6, 1'b0);
    wait_sync();
    chk("pin_run_sleep", 32'h1, {31'h0, pin_en});
    standby <= 1'b0;
    repeat (4)
    begin
      seed = xs(seed);
      v = seed[9:0];
      c0 = n_conv;
      apb(1'b1, dcc_pkg::IDX_DATA, {22'h0, v});
      apb(1'b1, dcc_pkg::IDX_DATA, {22'h0, ~v});
      idle();
      chk("busy_refused", 32'h1, {31'h0, err});
      wait_sync();
      chk("dac_code", {22'h0, v}, {22'h0, dac_code});
      chk("conv_starts", c0 + 1, n_conv);
    end
    seed = xs(seed);
    w = seed[9:0];
    wr(dcc_pkg::IDX_DATA_BUFFER_REG, {22'h0, w}, 1'b0);
    wait_sync();
    c0 = n_empty;
    fire();
    chk("buf_to_data", {22'h0, w}, {22'h0, dac_code});
    chk("empty_events", c0 + 1, n_empty);
    fire();
    apb(1'b0, dcc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h0);
    idle();
    chk("underrun", 32'h1, {31'h0, rd[dcc_pkg::FL_UNDERRUN]});
    chk("empty_flag", 32'h1, {31'h0, rd[dcc_pkg::FL_EMPTY]});
    wr(dcc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h1, 1'b0);
    wr(dcc_pkg::IDX_INTENSET, 32'h1, 1'b0);
    chk("irq_idle", 32'h0, {31'h0, irq});
    fire();
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(dcc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h1, 1'b0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    write_protect <= 1'b1;
    wr(dcc_pkg::IDX_INTENSET, 32'h2, 1'b1);
    wr(dcc_pkg::IDX_INTERRUPT_FLAG_REG, 32'h1, 1'b0);
    debugger_access <= 1'b1;
    wr(dcc_pkg::IDX_INTENCLR, 32'h1, 1'b0);
    write_protect <= 1'b0;
    debugger_access <= 1'b0;
    debug_halt <= 1'b1;
    seed = xs(seed);
    v = seed[9:0];
    wr(dcc_pkg::IDX_DATA_BUFFER_REG, {22'h0, v}, 1'b0);
    wait_sync();
    fire();
    chk("halted", {22'h0, w}, {22'h0, dac_code});
    debug_halt <= 1'b0;
    fire();
    chk("resumed", {22'h0, v}, {22'h0, dac_code});
    wr(dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h0, 1'b0);
    wait_sync();
    wr(dcc_pkg::IDX_EVENT_CONTROL_REG, 32'h5, 1'b0);
    ev_inv <= 1'b1;
    wr(dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h2, 1'b0);
    wait_sync();
    w = ~v;
    wr(dcc_pkg::IDX_DATA_BUFFER_REG, {22'h0, w}, 1'b0);
    wait_sync();
    fire();
    chk("falling_edge", {22'h0, w}, {22'h0, dac_code});
    wr(dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h1, 1'b0);
    wait_sync();
    rdc("secondary_control_reg_soft_reset_bit", dcc_pkg::IDX_SECONDARY_CONTROL_REG, 32'h0);
    rdc("primary_control_reg_soft_reset_bit", dcc_pkg::IDX_PRIMARY_CONTROL_REG, 32'h0);
    chk("ref_soft_reset_bit", 32'h0, {30'h0, ref_sel});
    complete_run();
  end
endmodule : dcc_top_tb_top
